// ==== hdl/oic_pkg.sv ====
// Package: constants and types for the overlapped instruction cycle control
// Summary of operation
// - Counter plus constant enters adder at t0
// - Add t1, decode t2, address lines t3
// - Missing acknowledge: delay, then repeat call
// - Fetched word gated t2, latched t3
// - Index field goes straight to selector
// - Index register read t3-t4, sent t5
// - Operand address plus index, call at t0
// - Second register gets op t5, address t7
// - Operation decoded statically while in second register
// - Unit control transferred at t5 after success
// - Fast field plus zero t2, selector t4
// - Fast register delivered t7 with memory operand
// - Execution starts t0 of fourth cycle
// - Result address held t7 through t6
// - Selector storage to selector at t6
// - Result read t1, written t2, clear-write
// - Five stages overlap, offset one cycle
// - Fast register operand: no memory call
// - Cycle split into eight pulse times
// - No memory operand: simulated acknowledge
package oic_pkg;
  // Field widths of the instruction word
  localparam int OP_W   = 8;
  localparam int FR_W   = 8;
  localparam int IX_W   = 8;
  localparam int ADDR_W = 16;
  localparam int WORD_W = OP_W + FR_W + IX_W + ADDR_W;
  localparam int DATA_W = 48;
  localparam int IX_LSD_W = 16;
  // Timing
  localparam int CLK_MHZ      = 250;
  localparam int CYCLE_NS     = 4000;
  localparam int PULSES       = 8;
  localparam int PULSE_NS     = CYCLE_NS / PULSES;
  localparam int PULSE_CYC    = PULSE_NS * CLK_MHZ / 1000;
  localparam int PULSE_CNT_W  = 7;
  localparam int RETRY_CYCLES = 1;
  // Fast register address prefix
  localparam logic [7:0] FAST_PREFIX = 8'hFF;
  localparam logic [ADDR_W-1:0] ZERO_ADDR = 16'h0000;

  typedef enum logic [2:0] {
    OIC_T0 = 3'h0, OIC_T1 = 3'h1, OIC_T2 = 3'h2, OIC_T3 = 3'h3,
    OIC_T4 = 3'h4, OIC_T5 = 3'h5, OIC_T6 = 3'h6, OIC_T7 = 3'h7
  } oic_pulse_t;

  typedef enum logic [2:0] {
    OIC_RUN   = 3'b001,
    OIC_WAIT  = 3'b010,
    OIC_RETRY = 3'b100
  } oic_call_t;

  typedef struct packed {
    logic [OP_W-1:0]   op;
    logic [FR_W-1:0]   fr;
    logic [IX_W-1:0]   ix;
    logic [ADDR_W-1:0] addr;
  } oic_word_t;

  typedef struct packed {
    logic [OP_W-1:0]   op;
    logic [FR_W-1:0]   fr;
    logic [ADDR_W-1:0] addr;
  } oic_ir2_t;

  // Adder shared by the call, index and operand select stages
  function automatic logic [ADDR_W-1:0] oic_add(
    input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
    oic_add = a + b;
  endfunction

  // Operand address names a fast register
  function automatic logic oic_is_fast(input logic [ADDR_W-1:0] a);
    oic_is_fast = (a[ADDR_W-1 -: 8] == FAST_PREFIX);
  endfunction
endpackage

// ==== hdl/oic_fast_regs.sv ====
// Small fast register memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module oic_fast_regs
  import oic_pkg::*;
#(
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic              clock_i,
  input  wire logic              rd_i,
  input  wire logic              wr_i,
  input  wire logic [AW-1:0]     addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  output logic      [DATA_W-1:0] rdata_o
);
  logic [DATA_W-1:0] mem_q [DEPTH];

  // Read out, clear-write on write
  always_ff @(posedge clock_i) begin
    if (wr_i) begin
      mem_q[addr_i] <= wdata_i;
    end
    if (rd_i) begin
      rdata_o <= mem_q[addr_i];
    end
  end
endmodule // oic_fast_regs
`default_nettype wire

// ==== hdl/oic_ctrl.sv ====
// Overlapped five stage instruction cycle control
`timescale 1ns/1ps
`default_nettype none
module oic_ctrl
  import oic_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              rst_n_i,
  input  wire logic              run_i,
  input  wire logic              mem_free_ack_i,
  input  wire logic [WORD_W-1:0] read_bus_i,
  input  wire logic [DATA_W-1:0] au_result_i,
  input  wire logic              no_operand_i,
  output logic      [ADDR_W-1:0] mem_addr_o,
  output logic                   inst_call_o,
  output logic                   oper_call_o,
  output logic [ADDR_W-1:0]      iac_o,
  output logic [OP_W-1:0]        op_decode_o,
  output logic                   op_valid_o,
  output logic                   au_ctrl_load_o,
  output logic [DATA_W-1:0]      au_a_operand_o,
  output logic [DATA_W-1:0]      au_m_operand_o,
  output logic                   au_start_o,
  output logic                   result_write_strobe_o,
  output logic [2:0]             pulse_o
);
  // ***************************************************
  // Pulse timer
  // ***************************************************
  logic [PULSE_CNT_W-1:0] div_q;
  logic [2:0]             tp_q;
  logic                   tick;
  assign tick = (div_q == PULSE_CNT_W'(PULSE_CYC - 1));

  // Eight pulse times per cycle, one tick each
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_q <= '0;
      tp_q  <= 3'h0;
    end else if (tick) begin
      div_q <= '0;
      tp_q  <= tp_q + 3'h1;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  logic at_t0, at_t1, at_t2, at_t3, at_t4, at_t5, at_t6, at_t7;
  assign at_t0 = tick && tp_q == OIC_T0;
  assign at_t1 = tick && tp_q == OIC_T1;
  assign at_t2 = tick && tp_q == OIC_T2;
  assign at_t3 = tick && tp_q == OIC_T3;
  assign at_t4 = tick && tp_q == OIC_T4;
  assign at_t5 = tick && tp_q == OIC_T5;
  assign at_t6 = tick && tp_q == OIC_T6;
  assign at_t7 = tick && tp_q == OIC_T7;
  assign pulse_o = tp_q;

  // ***************************************************
  // Instruction call stage
  // ***************************************************
  oic_call_t         call_q;
  logic [ADDR_W-1:0] iac_q, in1_q, in2_q, sum_q, dec_q, oper_addr_q;
  logic              call_ok_q, word_due_q, stall;
  logic              fetch_word_load_strobe, decoder_load_strobe;
  assign stall = (call_q != OIC_RUN);
  assign iac_o = iac_q;

  // Adder inputs: counter plus zero, sum, decode, call
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in1_q <= '0;
      in2_q <= '0;
      sum_q <= '0;
      dec_q <= '0;
      iac_q <= '0;
    end else begin
      if (at_t0) begin
        in1_q <= iac_q;
        in2_q <= ZERO_ADDR;
      end
      if (at_t1) begin
        sum_q <= oic_add(in1_q, in2_q);
      end
      if (decoder_load_strobe) begin
        dec_q <= sum_q;
      end
      if (at_t4 && mem_free_ack_i && run_i) begin
        iac_q <= oic_add(iac_q, 16'h0001); // Step only on success
      end
    end
  end
  assign decoder_load_strobe = at_t2 && run_i;
  assign inst_call_o = tp_q == OIC_T3 && run_i;
  assign mem_addr_o  = oper_call_o ? oper_addr_q : dec_q;

  // Call state: acknowledge at t4 or retry after a delay
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      call_q     <= OIC_RUN;
      call_ok_q  <= 1'b0;
      word_due_q <= 1'b0;
    end else begin
      if (at_t4 && run_i) begin
        call_ok_q <= mem_free_ack_i;
      end
      if (at_t7) begin
        word_due_q <= call_ok_q;
      end
      case (call_q)
        OIC_RUN:   if (at_t4 && run_i && !mem_free_ack_i) begin
                     call_q <= OIC_WAIT;
                   end
        OIC_WAIT:  if (at_t7) begin
                     call_q <= OIC_RETRY;
                   end
        OIC_RETRY: if (at_t4 && mem_free_ack_i) begin
                     call_q <= OIC_RUN;
                   end
        default:   call_q <= OIC_RUN;
      endcase
    end
  end

  // ***************************************************
  // First instruction register and index modification
  // ***************************************************
  oic_word_t         ir1_q;
  logic [WORD_W-1:0] gate_q;
  logic [IX_W-1:0]   sel_q;
  logic              ir1_full_q;
  logic [ADDR_W-1:0] badd1_q, badd2_q, bsum_q;
  logic [DATA_W-1:0] fr_rdata;
  logic              fr_rd, fr_wr;
  assign fetch_word_load_strobe = at_t2 && word_due_q && !stall;

  // Fetched word gated at t2, latched at t3
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gate_q     <= '0;
      ir1_q      <= '0;
      ir1_full_q <= 1'b0;
    end else begin
      if (fetch_word_load_strobe) begin
        gate_q <= read_bus_i;
      end
      if (at_t3) begin
        ir1_full_q <= word_due_q && !stall;
        if (word_due_q && !stall) begin
          ir1_q <= oic_word_t'(gate_q);
        end
      end
    end
  end

  // Index add: address t5, sum t6, decode t7
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      badd1_q     <= '0;
      badd2_q     <= '0;
      bsum_q      <= '0;
      oper_addr_q <= '0;
    end else begin
      if (at_t5 && ir1_full_q) begin
        badd1_q <= ir1_q.addr;
        badd2_q <= fr_rdata[IX_LSD_W-1:0];
      end
      if (at_t6) begin
        bsum_q <= oic_add(badd1_q, badd2_q);
      end
      if (at_t7) begin
        oper_addr_q <= bsum_q;
      end
    end
  end

  // ***************************************************
  // Second instruction register and operand select
  // ***************************************************
  oic_ir2_t          ir2_q;
  logic              ir2_full_q, op_ok_q, mem_op_q;
  logic [IX_W-1:0]   store_q;
  logic [ADDR_W-1:0] fsum_q;
  logic              needs_mem, sim_ack;
  assign needs_mem = !no_operand_i && !oic_is_fast(ir2_q.addr);
  assign oper_call_o = tp_q == OIC_T0 && ir2_full_q && needs_mem;
  assign sim_ack = !needs_mem;
  assign op_decode_o = ir2_q.op;
  assign op_valid_o  = ir2_full_q;

  // Op and fast fields at t5, modified address at t7
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ir2_q      <= '0;
      ir2_full_q <= 1'b0;
      op_ok_q    <= 1'b0;
      mem_op_q   <= 1'b0;
    end else begin
      if (at_t5) begin
        ir2_full_q <= ir1_full_q;
        if (ir1_full_q) begin
          ir2_q.op <= ir1_q.op;
          ir2_q.fr <= ir1_q.fr;
        end
      end
      if (at_t7 && ir1_full_q) begin
        ir2_q.addr <= bsum_q;
      end
      if (at_t1) begin
        op_ok_q  <= ir2_full_q && (sim_ack || mem_free_ack_i);
        mem_op_q <= ir2_full_q && needs_mem;
      end
    end
  end

  // Fast field plus zero at t2 and t4
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fsum_q  <= '0;
      store_q <= '0;
      sel_q   <= '0;
    end else begin
      if ((at_t2 || at_t4) && ir2_full_q) begin
        fsum_q <= oic_add({8'h00, ir2_q.fr}, ZERO_ADDR);
      end
      if (at_t6 && ir2_full_q) begin
        store_q <= fsum_q[IX_W-1:0];
      end
      if (fetch_word_load_strobe) begin
        sel_q <= read_bus_i[ADDR_W +: IX_W];
      end else if (at_t4 && ir2_full_q) begin
        sel_q <= fsum_q[IX_W-1:0];
      end else if (at_t6) begin
        sel_q <= store_q;
      end
    end
  end

  // ***************************************************
  // Arithmetic unit hand over and result store
  // ***************************************************
  logic [DATA_W-1:0] res_q;
  logic              exec_q, done_q;
  assign au_ctrl_load_o = at_t5 && op_ok_q;
  assign au_start_o     = at_t0 && exec_q;
  assign fr_rd = at_t4 || at_t6 || at_t1;
  assign fr_wr = at_t2 && result_write_strobe_o;

  // Delivery at t7, execution pulse and result hold
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      au_a_operand_o        <= '0;
      au_m_operand_o        <= '0;
      exec_q                <= 1'b0;
      done_q                <= 1'b0;
      res_q                 <= '0;
      result_write_strobe_o <= 1'b0;
    end else begin
      if (at_t7 && op_ok_q) begin
        au_a_operand_o <= fr_rdata;
        au_m_operand_o <= mem_op_q ? {8'h00, read_bus_i} : fr_rdata;
      end
      if (at_t7) begin
        exec_q <= op_ok_q;
        done_q <= exec_q;
      end
      if (at_t7 && exec_q) begin
        res_q <= au_result_i;
      end
      if (at_t1) begin
        result_write_strobe_o <= done_q;
      end else if (at_t3) begin
        result_write_strobe_o <= 1'b0;
      end
    end
  end

  oic_fast_regs u_fast (
    .clock_i (clock_i),
    .rd_i    (fr_rd),
    .wr_i    (fr_wr),
    .addr_i  (sel_q),
    .wdata_i (res_q),
    .rdata_o (fr_rdata)
  );

  // ***************************************************
  // Checks
  // ***************************************************
  // Clocks since the last tick, watched by the period check
  logic [7:0] gap_q;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gap_q <= 8'h00;
    end else begin
      gap_q <= tick ? 8'h00 : gap_q + 8'h01;
    end
  end

  sequence s_call_fail;
    at_t4 && run_i && !mem_free_ack_i && call_q == OIC_RUN;
  endsequence
  chk_retry_entry: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_call_fail |=> call_q == OIC_WAIT)
    else $error("failed call not delayed");
  chk_tick_period: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    tick == (gap_q == 8'(PULSE_CYC - 1)))
    else $error("pulse period wrong");
  chk_decode_load: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    decoder_load_strobe |=> dec_q == $past(sum_q))
    else $error("decoder not loaded from sum");
  chk_no_fast_call: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    oper_call_o |-> !oic_is_fast(ir2_q.addr))
    else $error("memory call for fast operand");
  chk_ctrl_at_t5: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    au_ctrl_load_o |-> tp_q == OIC_T5)
    else $error("unit control outside t5");
  chk_start_at_t0: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    au_start_o |-> tp_q == OIC_T0 && exec_q)
    else $error("execution start misplaced");
  chk_ir2_copy: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    at_t5 && ir1_full_q |=> ir2_q.op == $past(ir1_q.op))
    else $error("op field not copied");
  chk_write_window: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    result_write_strobe_o |-> tp_q == OIC_T2 || tp_q == OIC_T3)
    else $error("result written outside t2");
endmodule // oic_ctrl
`default_nettype wire

// ==== test/oic_mem_model.sv ====
// Core memory model answering instruction and operand calls
`timescale 1ns/1ps
`default_nettype none
module oic_mem_model
  import oic_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              rst_n_i,
  input  wire logic [2:0]        pulse_i,
  input  wire logic              inst_call_i,
  input  wire logic              oper_call_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              busy_i,
  input  wire logic              fast_i,
  output logic                   ack_o,
  output logic      [WORD_W-1:0] bus_o
);
  // ***********************
  // Call tracking
  // ***********************
  logic              ip_q, gr_q, fok_q, op_q;
  logic [ADDR_W-1:0] ia_q, fa_q, oa_q;
  logic [2:0]        pp_q;
  logic [7:0]        nz_q;
  // Free acknowledge: t4 for instruction, t1 for operand
  assign ack_o = (pulse_i == 3'h4 && ip_q && !busy_i) ||
                 (pulse_i == 3'h1 && op_q);
  // Word on t2-t3, operand on t7, moving noise otherwise
  assign bus_o = (fok_q && (pulse_i == 3'h2 || pulse_i == 3'h3)) ?
    {fa_q[7:0], 8'h03, 8'h03, (fast_i ? 8'hFF : 8'h01), fa_q[7:0]} :
    (op_q && pulse_i == 3'h7) ? {24'hA5A5A5, oa_q} : {5{nz_q}};
  // Latch addresses and grants on the pulse times
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {ip_q, gr_q, fok_q, op_q} <= 4'h0;
      ia_q <= '0;
      fa_q <= '0;
      oa_q <= '0;
      pp_q <= 3'h0;
      nz_q <= 8'h00;
    end else begin
      pp_q <= pulse_i;
      nz_q <= nz_q + 8'h01;
      if (pulse_i == 3'h3 && inst_call_i) begin
        ip_q <= 1'b1;
        ia_q <= addr_i;
      end
      if (ack_o && pulse_i == 3'h4) gr_q <= 1'b1;
      if (pulse_i == 3'h5 && pp_q == 3'h4) begin
        fok_q <= gr_q;
        fa_q <= ia_q;
        gr_q <= 1'b0;
        ip_q <= 1'b0;
      end
      if (pulse_i == 3'h0 && pp_q == 3'h7) op_q <= 1'b0;
      if (pulse_i == 3'h0 && oper_call_i) begin
        op_q <= 1'b1;
        oa_q <= addr_i;
      end
    end
  end
endmodule // oic_mem_model
`default_nettype wire

// ==== test/test_overlapped_instruction_cycle_ctrl.sv ====
// Testbench for the overlapped instruction cycle control
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) num_checks++; \
  if ((gt) !== (ex)) begin num_errors++; \
  $display("mismatch %s exp %0h got %0h", nm, ex, gt); end
module test_overlapped_instruction_cycle_ctrl;
  import oic_pkg::*;
  // ***********************
  // Signals and monitors
  // ***********************
  logic              clock_i, rst_n_i, run, ack, no_op, busy, fast, got4;
  logic [WORD_W-1:0] bus;
  logic [DATA_W-1:0] res, a_op, m_op;
  logic [ADDR_W-1:0] maddr, iac;
  logic [OP_W-1:0]   opd;
  logic              icall, ocall, opv, ctl, st, wr, wr_q;
  logic [2:0]        pulse;
  int num_errors, num_checks, cyc, n_start, n_oper, e_iac, n;
  logic [2:0]        start_p, ctrl_p, wr_p;
  oic_ctrl uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .run_i(run),
    .mem_free_ack_i(ack), .read_bus_i(bus), .au_result_i(res),
    .no_operand_i(no_op), .mem_addr_o(maddr), .inst_call_o(icall),
    .oper_call_o(ocall), .iac_o(iac), .op_decode_o(opd),
    .op_valid_o(opv), .au_ctrl_load_o(ctl), .au_a_operand_o(a_op),
    .au_m_operand_o(m_op), .au_start_o(st),
    .result_write_strobe_o(wr), .pulse_o(pulse));
  oic_mem_model mem (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .pulse_i(pulse), .inst_call_i(icall), .oper_call_i(ocall),
    .addr_i(maddr), .busy_i(busy), .fast_i(fast), .ack_o(ack),
    .bus_o(bus));
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  // Record where strobes land, count successful calls, cut hangs
  always @(negedge clock_i) begin
    cyc++;
    if (cyc > 40000) begin
      num_errors++;
      results();
    end
    if (st === 1'b1) begin
      start_p = pulse;
      n_start++;
    end
    if (ctl === 1'b1) ctrl_p = pulse;
    if (ocall === 1'b1) n_oper++;
    if (wr === 1'b1 && wr_q !== 1'b1) wr_p = pulse;
    wr_q = wr;
    if (pulse === 3'h4 && ack === 1'b1) got4 = 1'b1;
    if (pulse === 3'h5 && got4) begin
      e_iac++;
      got4 = 1'b0;
    end
  end
  // ***********************
  // Tasks
  // ***********************
  task automatic wp(input logic [2:0] p);
    do begin @(posedge clock_i); #1; end while (pulse !== p);
  endtask
  task automatic cycles(input int k);
    repeat (k) begin wp(3'h6); wp(3'h7); end
  endtask
  task automatic t_reset;
    `CHK("pulse", 3'h0, pulse)
    `CHK("iac", 16'h0000, iac)
    `CHK("valid", 1'b0, opv)
    `CHK("icall", 1'b0, icall)
    $display("test reset done");
  endtask
  task automatic t_pulse;
    wp(3'h1);
    n = 0;
    do begin @(posedge clock_i); #1; n++; end while (pulse !== 3'h2);
    `CHK("pulse_len", PULSE_CYC, n)
    $display("test pulse done");
  endtask
  task automatic t_busy;
    wp(3'h3);
    `CHK("icall", 1'b1, icall)
    `CHK("iaddr", 16'h0000, maddr)
    wp(3'h5);
    `CHK("iac", 16'h0001, iac)
    wp(3'h3);
    busy = 1'b1;
    wp(3'h5);
    `CHK("iac_held", 16'h0001, iac)
    busy = 1'b0;
    wp(3'h3);
    `CHK("re_addr", 16'h0001, maddr)
    wp(3'h5);
    `CHK("iac_next", 16'h0002, iac)
    $display("test busy done");
  endtask
  task automatic t_noop;
    cycles(5);
    n_oper = 0;
    ctrl_p = 3'h7;
    cycles(3);
    `CHK("no_call", 0, n_oper)
    `CHK("ctrl_p", 3'h5, ctrl_p)
    $display("test simulated ack done");
  endtask
  task automatic t_steady;
    no_op = 1'b0;
    cycles(3);
    n_start = 0;
    for (int i = 0; i < 4; i++) begin
      wp(3'h0);
      `CHK("ocall", 1'b1, ocall)
      `CHK("oaddr", {8'h01, 8'(e_iac - 2)}, maddr)
      `CHK("op", 8'(e_iac - 2), opd)
      `CHK("m_op", {24'hA5A5A5, 8'h01, 8'(e_iac - 3)}, m_op[39:0])
      `CHK("a_op", res, a_op)
      wp(3'h7);
    end
    `CHK("starts", 4, n_start)
    `CHK("start_p", 3'h0, start_p)
    `CHK("ctrl_p", 3'h5, ctrl_p)
    `CHK("wr_p", 3'h2, wr_p)
    $display("test steady done");
  endtask
  task automatic t_fast;
    fast = 1'b1;
    cycles(2);
    n_oper = 0;
    ctrl_p = 3'h7;
    cycles(3);
    `CHK("fast_call", 0, n_oper)
    `CHK("ctrl_p", 3'h5, ctrl_p)
    $display("test fast operand done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ***********************
  // Main sequence
  // ***********************
  initial begin
    {num_errors, num_checks, cyc, n_start, n_oper, e_iac} = '0;
    {rst_n_i, run, busy, fast, got4, wr_q} = '0;
    no_op = 1'b1;
    res = 48'h3C3C5A5A0000;
    repeat (10) @(posedge clock_i);
    #1;
    rst_n_i = 1'b1;
    run = 1'b1;
    t_reset();
    t_pulse();
    t_busy();
    t_noop();
    t_steady();
    t_fast();
    results();
  end
endmodule // test_overlapped_instruction_cycle_ctrl
`default_nettype wire
